// *** core/dma_status_mask_mode.sv ***
`timescale 1ns/100ps
module dma_status_mask_mode
	import dma_regs_pkg::*;
(
	input wire logic CLK_I, // 25 MHz core clock
	input wire logic RESET_I, // synchronous part reset, active high
	input wire logic [7:0] IO_ADDR_I, // i/o port address
	input wire logic [7:0] IO_WDATA_I, // write data
	input wire logic IO_WR_I, // write strobe, one cycle
	input wire logic IO_RD_I, // read strobe, one cycle
	input wire logic MASTER_CLEAR_I, // master clear command pulse
	input wire logic [7:0] HW_REQ_I, // hardware request per channel
	input wire logic [7:0] SW_REQ_I, // software request per channel
	input wire logic [7:0] TC_I, // terminal count pulse per channel
	output logic [7:0] IO_RDATA_O, // read data, registered
	output logic [7:0] MASK_O, // channel masks, 1 = masked
	output logic [7:0] REQ_ACTIVE_O, // unmasked requests to arbiter
	output logic [7:0] RELOAD_O, // reload current from base, pulse
	output logic [7:0] DECREMENT_O, // address direction per channel
	output logic [15:0] XFER_MODE_O, // transfer mode, 2 bits per channel
	output logic [15:0] XFER_TYPE_O // effective type, 2 bits per channel
);
	channel_mode_type mode_reg [8];
	channel_mode_type mode_next [8];
	logic [7:0] mask_reg, mask_next;
	logic [7:0] tc_reg, tc_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [7:0] reload_reg, reload_next;
	logic [7:0] active_reg, active_next;
	logic [7:0] dec_reg, dec_next;
	logic [15:0] xmode_reg, xmode_next;
	logic [15:0] xtype_reg, xtype_next;
	logic [7:0] pending;
	logic clear_all;

	function automatic logic [7:0] status_byte(input logic [3:0] req,
		input logic [3:0] tc);
		status_byte = {req, tc};
	endfunction

	assign clear_all = RESET_I | MASTER_CLEAR_I;

	always_comb begin
		pending = HW_REQ_I | SW_REQ_I;
		pending[4] = pending[4] | (|pending[3:0]);
	end

	always_comb begin
		mask_next = mask_reg;
		tc_next = tc_reg;
		rdata_next = 8'h00;
		reload_next = 8'h00;
		for (int c = 0; c < 8; c++) begin
			mode_next[c] = mode_reg[c];
		end
		if (IO_RD_I && IO_ADDR_I == LOW_STATUS_ADDR) begin
			rdata_next = status_byte(pending[3:0], tc_reg[3:0]);
			tc_next[3:0] = 4'h0;
		end
		if (IO_RD_I && IO_ADDR_I == HIGH_STATUS_ADDR) begin
			// channel 4 tc bit is meaningless; it is reported as recorded and cleared with the others
			rdata_next = status_byte(pending[7:4], tc_reg[7:4]);
			tc_next[7:4] = 4'h0;
		end
		if (IO_WR_I) begin
			if (IO_ADDR_I == LOW_MASK_ADDR) begin
				// upper bits are expected zero and ignored
				mask_next[IO_WDATA_I[1:0]] =
					IO_WDATA_I[MASK_BIT_POS];
			end
			if (IO_ADDR_I == HIGH_MASK_ADDR) begin
				mask_next[{1'b1, IO_WDATA_I[1:0]}] =
					IO_WDATA_I[MASK_BIT_POS];
			end
			if (IO_ADDR_I == LOW_MODE_ADDR) begin
				mode_next[{1'b0, IO_WDATA_I[1:0]}] =
					IO_WDATA_I[7:2];
			end
			if (IO_ADDR_I == HIGH_MODE_ADDR) begin
				mode_next[{1'b1, IO_WDATA_I[1:0]}] =
					IO_WDATA_I[7:2];
			end
		end
		for (int c = 0; c < 8; c++) begin
			if (TC_I[c]) begin
				tc_next[c] = 1'b1;
				if (mode_reg[c].auto_init) begin
					reload_next[c] = 1'b1;
				end else begin
					mask_next[c] = 1'b1;
				end
			end
		end
		if (clear_all) begin
			mask_next = {MASK_RESET, MASK_RESET};
			tc_next = 8'h00;
			reload_next = 8'h00;
			for (int c = 0; c < 8; c++) begin
				mode_next[c].decrement = 1'b0;
				mode_next[c].auto_init = 1'b0;
			end
		end
	end

	always_comb begin
		active_next = pending & ~mask_next;
		for (int c = 0; c < 8; c++) begin
			dec_next[c] = mode_next[c].decrement;
			xmode_next[2*c +: 2] = mode_next[c].xfer_mode;
			if (mode_next[c].xfer_mode == XFER_CASCADE) begin
				xtype_next[2*c +: 2] = TYPE_VERIFY;
			end else begin
				xtype_next[2*c +: 2] = mode_next[c].xfer_type;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			for (int c = 0; c < 8; c++) begin
				mode_reg[c] <= MODE_RESET;
			end
			mask_reg <= 8'hFF;
			tc_reg <= 8'h00;
			rdata_reg <= 8'h00;
			reload_reg <= 8'h00;
			active_reg <= 8'h00;
			dec_reg <= 8'h00;
			xmode_reg <= 16'h0000;
			xtype_reg <= 16'h0000;
		end else begin
			for (int c = 0; c < 8; c++) begin
				mode_reg[c] <= mode_next[c];
			end
			mask_reg <= mask_next;
			tc_reg <= tc_next;
			rdata_reg <= rdata_next;
			reload_reg <= reload_next;
			active_reg <= active_next;
			dec_reg <= dec_next;
			xmode_reg <= xmode_next;
			xtype_reg <= xtype_next;
		end
	end

	assign IO_RDATA_O = rdata_reg;
	assign MASK_O = mask_reg;
	assign REQ_ACTIVE_O = active_reg;
	assign RELOAD_O = reload_reg;
	assign DECREMENT_O = dec_reg;
	assign XFER_MODE_O = xmode_reg;
	assign XFER_TYPE_O = xtype_reg;
endmodule

// *** core/dma_regs_pkg.sv ***
// Function
// - status bits 7:4 show pending request per channel, bit 4 first channel
// - pending request comes from hardware request line or software request
// - upper group channel 4 request status is its own request ORed with channels 0 to 3
// - status bits 3:0 show terminal count reached per channel
// - terminal count bit of cascade channel 4 carries no meaning
// - single mask write bit 2 masks, clear unmasks selected channel
// - single mask bits 1:0 select one of the group's four channels
// - single mask write changes exactly one channel's mask bit
// - mode bits 7:6 transfer mode demand, single, cascade; 10 reserved
// - mode bit 5 picks decrement; increment after reset or master clear
// - mode bit 4 clear stops at terminal count; reset clears it
// - mode bit 4 set reloads current address and count from base
// - mode bits 3:2 transfer type verify, write, read; 11 illegal
// - cascade mode ignores the transfer type field
// - mode bits 1:0 pick which channel mode register takes bits 7:2
// - master clear clears status, decrement and autoinitialize bits, sets masks
// - terminal count sets channel mask unless autoinitialize enabled
package dma_regs_pkg;
	localparam logic [7:0] LOW_STATUS_ADDR = 8'h08;
	localparam logic [7:0] LOW_MASK_ADDR = 8'h0A;
	localparam logic [7:0] LOW_MODE_ADDR = 8'h0B;
	localparam logic [7:0] HIGH_STATUS_ADDR = 8'hD0;
	localparam logic [7:0] HIGH_MASK_ADDR = 8'hD4;
	localparam logic [7:0] HIGH_MODE_ADDR = 8'hD6;
	localparam int MASK_BIT_POS = 2;
	localparam int MODE_XFER_LSB = 6;
	localparam int MODE_DEC_POS = 5;
	localparam int MODE_AUTO_POS = 4;
	localparam int MODE_TYPE_LSB = 2;
	localparam logic [3:0] MASK_RESET = 4'hF;
	localparam logic [5:0] MODE_RESET = 6'h00;

	typedef enum logic [1:0] {
		XFER_DEMAND = 2'h0,
		XFER_SINGLE = 2'h1,
		XFER_RESERVED = 2'h2,
		XFER_CASCADE = 2'h3
	} xfer_mode_type;

	typedef enum logic [1:0] {
		TYPE_VERIFY = 2'h0,
		TYPE_WRITE = 2'h1,
		TYPE_READ = 2'h2,
		TYPE_ILLEGAL = 2'h3
	} xfer_type_type;

	typedef struct packed {
		xfer_mode_type xfer_mode;
		logic decrement;
		logic auto_init;
		xfer_type_type xfer_type;
	} channel_mode_type;
endpackage

// *** test/dma_smm_sva.sv ***
`timescale 1ns/100ps
module dma_smm_sva
	import dma_regs_pkg::*;
(
	input wire logic CLK_I, // clock
	input wire logic RESET_I, // reset
	input wire logic [7:0] IO_ADDR_I, // address
	input wire logic [7:0] IO_WDATA_I, // data
	input wire logic IO_WR_I, // write
	input wire logic IO_RD_I, // read
	input wire logic MASTER_CLEAR_I, // clear
	input wire logic [7:0] HW_REQ_I, // hw req
	input wire logic [7:0] SW_REQ_I, // sw req
	input wire logic [7:0] TC_I, // tc
	input wire logic [7:0] IO_RDATA_O, // rdata
	input wire logic [7:0] MASK_O, // masks
	input wire logic [7:0] REQ_ACTIVE_O, // active requests
	input wire logic [7:0] RELOAD_O, // reload
	input wire logic [7:0] DECREMENT_O, // dir
	input wire logic [15:0] XFER_MODE_O, // mode
	input wire logic [15:0] XFER_TYPE_O // type
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	sequence s_mask_wr;
		IO_WR_I && IO_ADDR_I == LOW_MASK_ADDR && !MASTER_CLEAR_I && TC_I == 8'h00;
	endsequence
	a_mask_select: assert property (s_mask_wr |=>
		MASK_O[$past(IO_WDATA_I[1:0])] == $past(IO_WDATA_I[2])) else $error("mask");
	a_active_unmasked: assert property ((REQ_ACTIVE_O & MASK_O) == 8'h00)
		else $error("masked request active");
	a_clear_masks: assert property (MASTER_CLEAR_I |=> MASK_O == 8'hFF)
		else $error("clear mask");
	a_clear_dir: assert property (MASTER_CLEAR_I |=> DECREMENT_O == 8'h00)
		else $error("clear dir");
	a_tc_masks: assert property (TC_I[0] && !MASTER_CLEAR_I |=>
		MASK_O[0] || RELOAD_O[0]) else $error("tc mask");
	a_reload_cause: assert property (RELOAD_O[1] |-> $past(TC_I[1]))
		else $error("reload");
	a_cascade_type: assert property (XFER_MODE_O[7:6] == 2'h3 |->
		XFER_TYPE_O[7:6] == 2'h0) else $error("cascade type");
	a_mode_select: assert property (IO_WR_I && IO_ADDR_I == LOW_MODE_ADDR &&
		IO_WDATA_I[1:0] == 2'h0 |=> XFER_MODE_O[1:0] == $past(IO_WDATA_I[7:6]))
		else $error("mode");
	a_req_status: assert property (IO_RD_I && IO_ADDR_I == LOW_STATUS_ADDR |=>
		IO_RDATA_O[7:4] == ($past(HW_REQ_I[3:0]) | $past(SW_REQ_I[3:0])))
		else $error("status");
endmodule

// *** test/dma_periph.sv ***
`timescale 1ns/100ps
module dma_periph (
	input wire logic clk_i, // bench clock
	input wire logic [7:0] want_i, // requests to raise
	output logic [7:0] req_o // request lines
);
	logic [7:0] line_reg = 8'h00;
	// levels change just after the falling edge and are held
	always @(negedge clk_i) line_reg <= want_i;
	assign req_o = line_reg;
endmodule

// *** test/dma_status_mask_mode_test.sv ***
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module dma_status_mask_mode_test;
	import dma_regs_pkg::*;
	logic clk = 0, rst = 1, wr = 0, rd = 0, mc = 0;
	logic [7:0] addr = 0, wd = 0, sw = 0, tc = 0, want = 0, hw;
	logic [7:0] rdata, mask, act, rel, dec;
	logic [15:0] mode, typ;
	int errors = 0, num_checks = 0;
	always #20 clk = ~clk;
	dma_periph per (.clk_i(clk), .want_i(want), .req_o(hw));
	dma_status_mask_mode dut (.CLK_I(clk), .RESET_I(rst), .IO_ADDR_I(addr),
		.IO_WDATA_I(wd), .IO_WR_I(wr), .IO_RD_I(rd), .MASTER_CLEAR_I(mc),
		.HW_REQ_I(hw), .SW_REQ_I(sw), .TC_I(tc), .IO_RDATA_O(rdata),
		.MASK_O(mask), .REQ_ACTIVE_O(act), .RELOAD_O(rel), .DECREMENT_O(dec),
		.XFER_MODE_O(mode), .XFER_TYPE_O(typ));
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wd = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
		@(negedge clk);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		addr = a;
		rd = 1;
		@(negedge clk);
		rd = 0;
		`CHK("rdata", e, rdata)
		@(negedge clk);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		end_sim;
	end
	initial begin
		repeat (5) @(negedge clk);
		rst = 0;
		`CHK("mask", 8'hFF, mask)
		for (int c = 0; c < 4; c++) wr_reg(LOW_MASK_ADDR, 8'(c));
		`CHK("mask", 8'hF0, mask)
		wr_reg(LOW_MASK_ADDR, 8'h05);
		wr_reg(HIGH_MASK_ADDR, 8'h00);
		`CHK("mask", 8'hE2, mask)
		for (int i = 0; i < 4; i++) wr_reg(LOW_MODE_ADDR, {2'(i), 2'h2, 2'(i), 2'(i)});
		`CHK("mode", 8'hE4, mode[7:0])
		`CHK("type", 8'h24, typ[7:0])
		`CHK("dir", 8'h0F, dec)
		wr_reg(LOW_MODE_ADDR, 8'h51);
		want = 8'h05;
		sw = 8'h80;
		tc = 8'h03;
		@(negedge clk);
		tc = 0;
		`CHK("reload", 8'h02, rel)
		`CHK("mask", 8'hE3, mask)
		rd_reg(LOW_STATUS_ADDR, 8'h53);
		rd_reg(LOW_STATUS_ADDR, 8'h50);
		rd_reg(HIGH_STATUS_ADDR, 8'h90);
		`CHK("active", 8'h14, act)
		rd_reg(8'h55, 8'h00);
		wr_reg(HIGH_MODE_ADDR, 8'hC2);
		`CHK("mode", 8'h30, mode[15:8])
		`CHK("type", 8'h00, typ[15:8])
		mc = 1;
		@(negedge clk);
		mc = 0;
		`CHK("mask", 8'hFF, mask)
		`CHK("dir", 8'h00, dec)
		tc = 8'h02;
		@(negedge clk);
		tc = 0;
		`CHK("reload", 8'h00, rel)
		end_sim;
	end
endmodule
bind dma_status_mask_mode dma_smm_sva chk (.*);
